/* File: hw/lfd_fault_diag.sv */
// fault monitoring, response policy and short-to-ground/battery diagnostic status
`timescale 1ns/100ps
`include "lfd_params.svh"

// Summary of operation
// - per-output active-low battery short flag, 0 when shorted to battery.
// - per-output active-low ground short flag, 0 when shorted to ground.
// - per-output active-low offset flag, 0 when differential offset exceeds threshold.
// - offset flags are live; host trusts them only in play mode, no signal.
// - in normal mode, shorted load or overcurrent latch that channel high impedance; a detected short and others don't.
// - overvoltage drives outputs to half supply, unlatched, reported on the fault pin, not in status.
// - load results in status; on clip pin a only when mapped.
// - short diagnostic runs while enable set; results live, read during diagnostic.
// - short status names the channel, not the polarity of the pair.
// - with standby select 0 outputs biased; above level battery, below low limit ground.
// - a detected short does not block power-up; overcurrent in normal mode latches the channel off.
// - latched overcurrent flag cleared by writing 1, and by reset.
module lfd_fault_diag #(
   parameter int NUM_CH     = `LFD_NUM_CH,
   parameter int SETTLE_CYC = `LFD_SETTLE_CYC,
   parameter logic VERSION  = 1'b0 // arbitrary version code
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // control bits from the serial register bank
   input  wire logic              shortDiagEnable,
   input  wire logic              standbySelect,
   input  wire logic              normalMode,
   input  wire logic              loadMapClip,
   input  wire logic [NUM_CH-1:0] overcurrentClearW1,
   // raw comparator levels, asynchronous
   input  wire logic [NUM_CH-1:0] cmpAboveBias,
   input  wire logic [NUM_CH-1:0] cmpBelowLow,
   input  wire logic [NUM_CH-1:0] cmpOffsetHigh,
   input  wire logic [NUM_CH-1:0] cmpOvercurrent,
   input  wire logic [NUM_CH-1:0] cmpShortedLoad,
   input  wire logic [NUM_CH-1:0] cmpClip,
   input  wire logic              cmpOvervoltage,
   // status registers
   output logic [7:0]             outputShortStatus,
   output logic [7:0]             offsetAndVersionStatus,
   output logic [NUM_CH-1:0]      overcurrent_n,
   output logic                   diagResultValid,
   // output stage control
   output logic [NUM_CH-1:0]      channelHighZ,
   output logic                   outputsHalfSupply,
   // open-drain pins
   output logic                   faultPinOut,
   output logic                   faultPinOe,
   output logic                   clipOutAOut,
   output logic                   clipOutAOe,
   output logic                   muteClipOutBOut,
   output logic                   muteClipOutBOe
);
   localparam int SYNC_W = 5 * NUM_CH + 1;
   localparam int CNT_W  = $clog2(SETTLE_CYC + 1);
   // offset flags idle at within threshold, matching the cleared synchroniser
   localparam logic [7:0] OFF_RST = `LFD_OFFSET_RST | (8'(VERSION) << `LFD_VERSION_BIT);

   logic [SYNC_W-1:0] rawBus;
   logic [SYNC_W-1:0] syncBus;
   logic [NUM_CH-1:0] aboveS, belowS, offS, ocS, slS, clipS;
   logic              ovS;

   assign rawBus = {cmpOvervoltage, cmpClip, cmpShortedLoad, cmpOvercurrent,
                    cmpOffsetHigh, cmpAboveBias};

   lfd_sync #(.WIDTH(SYNC_W + NUM_CH), .RST_VAL('0)) uSync (
      .clk     (clk),
      .reset   (reset),
      .asyncIn ({rawBus, cmpBelowLow}),
      .syncOut ({syncBus, belowS})
   );

   assign {ovS, clipS, slS, ocS, offS, aboveS} = syncBus;

   // diagnostic sequencing state
   lfd_pkg::lfd_diag_t diag_q, diag_d;
   logic [CNT_W-1:0]   cnt_q, cnt_d;

   always_comb begin
      diag_d = diag_q;
      cnt_d  = cnt_q;
      case (diag_q)
         lfd_pkg::LFD_IDLE: begin
            cnt_d = '0;
            if (shortDiagEnable) begin
               diag_d = lfd_pkg::LFD_SETTLE;
            end
         end
         lfd_pkg::LFD_SETTLE: begin
            if (!shortDiagEnable) begin
               diag_d = lfd_pkg::LFD_IDLE;
            end else if (cnt_q == CNT_W'(SETTLE_CYC - 1)) begin
               diag_d = lfd_pkg::LFD_VALID;
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         lfd_pkg::LFD_VALID: begin
            if (!shortDiagEnable) begin
               diag_d = lfd_pkg::LFD_IDLE;
            end
         end
         default: diag_d = lfd_pkg::LFD_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         diag_q <= lfd_pkg::LFD_IDLE;
         cnt_q  <= '0;
      end else begin
         diag_q <= diag_d;
         cnt_q  <= cnt_d;
      end
   end

   // latched per-channel protection state
   logic [NUM_CH-1:0] ocLatch_q, ocLatch_d;
   logic [NUM_CH-1:0] hiz_q, hiz_d;
   logic [7:0]        shortStat_q, shortStat_d;
   logic [7:0]        offStat_q, offStat_d;
   logic [NUM_CH-1:0] batN, gndN;
   logic              diagOn;

   assign diagOn = shortDiagEnable && (diag_q != lfd_pkg::LFD_IDLE);

   always_comb begin
      batN = {NUM_CH{1'b1}};
      gndN = {NUM_CH{1'b1}};
      if (diagOn) begin
         // above bias is battery, below low limit is ground
         batN = ~aboveS;
         gndN = ~belowS;
         // standby select picks which test is meaningful
         if (standbySelect) begin
            gndN = {NUM_CH{1'b1}};
         end
      end
      // one bit per channel, polarity not resolved
      // live values, nothing held after the diagnostic
      shortStat_d = `LFD_STATUS_RST;
      shortStat_d[`LFD_SHORT_BAT_LSB +: NUM_CH] = batN;
      shortStat_d[`LFD_SHORT_GND_LSB +: NUM_CH] = gndN;
      offStat_d = 8'h00;
      offStat_d[`LFD_OFFSET_LSB +: NUM_CH] = ~offS;
      offStat_d[`LFD_VERSION_BIT] = VERSION;
      // write-one clear, a new event wins over the clear
      // overcurrent latches the channel even when powered into a short
      ocLatch_d = (ocLatch_q & ~overcurrentClearW1) | (normalMode ? ocS : '0);
      // shorted load or overcurrent latch high impedance
      hiz_d = (hiz_q & ~overcurrentClearW1) | (normalMode ? (ocS | slS) : '0);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ocLatch_q   <= '0;
         hiz_q       <= '0;
         shortStat_q <= `LFD_STATUS_RST;
         offStat_q   <= OFF_RST;
      end else begin
         ocLatch_q   <= ocLatch_d;
         hiz_q       <= hiz_d;
         shortStat_q <= shortStat_d;
         offStat_q   <= offStat_d;
      end
   end

   assign outputShortStatus      = shortStat_q;
   assign offsetAndVersionStatus = offStat_q;
   assign overcurrent_n          = ~ocLatch_q;
   assign channelHighZ           = hiz_q;
   // results trusted only after the settle time
   assign diagResultValid        = (diag_q == lfd_pkg::LFD_VALID);
   assign outputsHalfSupply      = ovS;

   // open-drain pins: out is always low, enable pulls the wire
   logic loadAny, clipAny;
   // load results reach the clip pin only when mapped
   assign loadAny = loadMapClip && diagOn && (~&batN || ~&gndN);
   // clip reported on both pins in normal mode only, no output action
   assign clipAny = normalMode && (|clipS);

   assign faultPinOut     = 1'b0;
   assign faultPinOe      = ovS | (|ocLatch_q);
   assign clipOutAOut     = 1'b0;
   assign clipOutAOe      = clipAny | loadAny;
   assign muteClipOutBOut = 1'b0;
   assign muteClipOutBOe  = clipAny;

   a_oc_latch_holds: assert property (@(posedge clk) disable iff (reset)
      ((ocLatch_q | $past(overcurrentClearW1)) & $past(ocLatch_q)) == $past(ocLatch_q))
      else $error("overcurrent latch dropped without clear");

   a_hiz_on_oc: assert property (@(posedge clk) disable iff (reset)
      normalMode |=> ((channelHighZ & $past(ocS)) == $past(ocS)) &&
                     ((~overcurrent_n & $past(ocS)) == $past(ocS)))
      else $error("overcurrent did not latch channel off");

   a_hiz_on_sl: assert property (@(posedge clk) disable iff (reset)
      normalMode |=> ((channelHighZ & $past(slS)) == $past(slS)))
      else $error("shorted load did not latch channel off");

   a_standby_no_latch: assert property (@(posedge clk) disable iff (reset)
      (!normalMode && ocLatch_q == '0) |=> ocLatch_q == '0)
      else $error("overcurrent latched outside normal mode");

   a_halfsup_live: assert property (@(posedge clk) disable iff (reset)
      cmpOvervoltage |-> ##2 outputsHalfSupply)
      else $error("half supply not following overvoltage");

   a_halfsup_drop: assert property (@(posedge clk) disable iff (reset)
      !cmpOvervoltage |-> ##2 !outputsHalfSupply)
      else $error("half supply held after overvoltage");

   a_ov_fault_pin: assert property (@(posedge clk) disable iff (reset)
      ovS |-> faultPinOe)
      else $error("overvoltage not on fault pin");

   a_oc_fault_pin: assert property (@(posedge clk) disable iff (reset)
      !(&overcurrent_n) |-> faultPinOe)
      else $error("latched overcurrent not on fault pin");

   a_clip_pins: assert property (@(posedge clk) disable iff (reset)
      (normalMode && |clipS) |-> (clipOutAOe && muteClipOutBOe))
      else $error("clip not reported on pins");

   // pin b only in normal mode
   a_pinb_clip_only: assert property (@(posedge clk) disable iff (reset)
      !normalMode |-> !muteClipOutBOe)
      else $error("clip pin b driven outside normal mode");

   a_bat_flag_live: assert property (@(posedge clk) disable iff (reset)
      diagOn |=>
         outputShortStatus[`LFD_SHORT_BAT_LSB +: NUM_CH] == ~$past(aboveS))
      else $error("battery short flags wrong");

   a_gnd_flag_live: assert property (@(posedge clk) disable iff (reset)
      (diagOn && !standbySelect) |=>
         outputShortStatus[`LFD_SHORT_GND_LSB +: NUM_CH] == ~$past(belowS))
      else $error("ground short flags wrong");

   a_gnd_masked: assert property (@(posedge clk) disable iff (reset)
      (diagOn && standbySelect) |=> &outputShortStatus[`LFD_SHORT_GND_LSB +: NUM_CH])
      else $error("ground flags shown during battery test");

   a_short_idle: assert property (@(posedge clk) disable iff (reset)
      (!shortDiagEnable && $past(!shortDiagEnable)) |=> outputShortStatus == 8'hFF)
      else $error("short status held after diagnostic");

   a_idle_no_valid: assert property (@(posedge clk) disable iff (reset)
      !shortDiagEnable |=> !diagResultValid)
      else $error("results valid without diagnostic");

   a_offset_live: assert property (@(posedge clk) disable iff (reset)
      offS[0] |=> !offsetAndVersionStatus[0])
      else $error("offset flag not reporting");

   a_offset_follow: assert property (@(posedge clk) disable iff (reset)
      1'b1 |=> offsetAndVersionStatus[`LFD_OFFSET_LSB +: NUM_CH] == ~$past(offS))
      else $error("offset flags not live");

   a_settle_time: assert property (@(posedge clk) disable iff (reset)
      $rose(shortDiagEnable) |-> !diagResultValid [*8])
      else $error("results valid before settle time");

   a_valid_needs_enable: assert property (@(posedge clk) disable iff (reset)
      diagResultValid |-> $past(shortDiagEnable))
      else $error("results valid after enable dropped");

   a_map_gate: assert property (@(posedge clk) disable iff (reset)
      (!loadMapClip && !clipAny) |-> !clipOutAOe)
      else $error("clip pin driven while unmapped");

   a_load_map: assert property (@(posedge clk) disable iff (reset)
      (loadMapClip && diagOn && !(&batN && &gndN)) |-> clipOutAOe)
      else $error("mapped short result not on clip pin");
endmodule

/* File: hw/lfd_sync.sv */
// two-flop synchroniser for a bus of comparator levels
`timescale 1ns/100ps
module lfd_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // levels
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage1_q <= RST_VAL;
         stage2_q <= RST_VAL;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
      end
   end

   assign syncOut = stage2_q;
endmodule

/* File: pkg/lfd_params.svh */
// timing counts, field positions and reset values of the fault and short-diagnostic block
`ifndef LFD_PARAMS_SVH
`define LFD_PARAMS_SVH
`define LFD_NUM_CH            4
`define LFD_SHORT_BAT_LSB     4
`define LFD_SHORT_GND_LSB     0
`define LFD_VERSION_BIT       4
`define LFD_OFFSET_LSB        0
`define LFD_STATUS_RST        8'hFF
`define LFD_OFFSET_RST        8'h0F
`define LFD_OVERCUR_RST       4'hF
`define LFD_CLK_MHZ           100
`define LFD_SETTLE_US         200
`define LFD_SETTLE_CYC        (`LFD_SETTLE_US * `LFD_CLK_MHZ)
`endif

/* File: pkg/lfd_pkg.sv */
// types of the fault and short-diagnostic block
package lfd_pkg;
   typedef enum logic [1:0] {
      LFD_IDLE   = 2'b00,
      LFD_SETTLE = 2'b01,
      LFD_VALID  = 2'b10
   } lfd_diag_t;
endpackage

/* File: verif/lfd_host_model.sv */
// host-side model driving the short-diagnostic control bits
`timescale 1ns/100ps
module lfd_host_model #(
   parameter int SETTLE_CYC = 10
) (
   // clock
   input  wire logic       clk,
   // device status
   input  wire logic [7:0] outputShortStatus,
   input  wire logic       diagResultValid,
   input  wire logic [1:0] clipPins,
   // control bits
   output logic            shortDiagEnable,
   output logic            standbySelect,
   output logic            normalMode
);
   initial begin
      shortDiagEnable = 1'b0;
      standbySelect   = 1'b0;
      normalMode      = 1'b1;
   end
   task automatic set_mode(input logic normal);
      @(negedge clk);
      normalMode = normal;
   endtask
   // normal mode, outputs discharged off-model before the run
   task automatic short_diag(input logic sel, output logic [7:0] st, output logic [7:0] w,
                             output logic [1:0] pins);
      w = 8'h00;
      @(negedge clk);
      // select test polarity, run while enable high
      standbySelect   = sel;
      shortDiagEnable = 1'b1;
      // results trusted only after the settle time, bounded wait
      while (diagResultValid !== 1'b1 && w < 8'(SETTLE_CYC + 5)) begin
         @(negedge clk);
         w++;
      end
      // results are live, so read before dropping enable
      st = outputShortStatus;
      pins = clipPins;
      @(negedge clk);
      shortDiagEnable = 1'b0;
   endtask
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the fault and short-diagnostic block
`timescale 1ns/100ps
module tb_top;
   localparam int SETTLE = 10;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic       shortDiagEnable, standbySelect, normalMode, diagResultValid, outputsHalfSupply;
   logic       loadMapClip = 1'b0;
   logic       cmpOvervoltage = 1'b0;
   logic [3:0] overcurrentClearW1 = 4'h0, cmpClip = 4'h0, cmpShortedLoad = 4'h0;
   logic [3:0] cmpAboveBias = 4'h0, cmpBelowLow = 4'h0, cmpOffsetHigh = 4'h0;
   logic [3:0] cmpOvercurrent = 4'h0, overcurrent_n, channelHighZ;
   logic [7:0] outputShortStatus, offsetAndVersionStatus;
   logic       faultPinOut, faultPinOe, clipOutAOut, clipOutAOe, muteClipOutBOut, muteClipOutBOe;
   int         nMismatch = 0;
   int         compares = 0;
   // open-drain pins idle high through pull-ups
   wire        faultPin = faultPinOe ? faultPinOut : 1'b1;
   wire [1:0]  clipPins = {clipOutAOe ? clipOutAOut : 1'b1, muteClipOutBOe ? muteClipOutBOut : 1'b1};
   always #5 clk = ~clk;
   lfd_fault_diag #(.SETTLE_CYC(SETTLE)) dut_u (.clk, .reset, .shortDiagEnable, .standbySelect,
      .normalMode, .loadMapClip, .overcurrentClearW1, .cmpAboveBias, .cmpBelowLow, .cmpOffsetHigh,
      .cmpOvercurrent, .cmpShortedLoad, .cmpClip, .cmpOvervoltage, .outputShortStatus,
      .offsetAndVersionStatus, .overcurrent_n, .diagResultValid, .channelHighZ, .outputsHalfSupply,
      .faultPinOut, .faultPinOe, .clipOutAOut, .clipOutAOe, .muteClipOutBOut, .muteClipOutBOe);
   lfd_host_model #(.SETTLE_CYC(SETTLE)) host_u (.clk, .outputShortStatus, .diagResultValid,
      .clipPins, .shortDiagEnable, .standbySelect, .normalMode);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         nMismatch++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, nMismatch);
      if (nMismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic t_short;
      logic [7:0] st, w;
      logic [1:0] pins;
      cmpBelowLow  = 4'h5;
      cmpAboveBias = 4'h2;
      loadMapClip  = 1'b1;
      cyc(3);
      chk(outputShortStatus, 8'hFF);
      chk(8'(clipPins), 8'h03);
      host_u.short_diag(1'b0, st, w, pins);
      chk(w, 8'(SETTLE + 1));
      chk(8'(st[7:4]), 8'h0D);
      chk(8'(st[3:0]), 8'h0A);
      chk(8'(pins), 8'h01);
      loadMapClip = 1'b0;
      host_u.short_diag(1'b1, st, w, pins);
      chk(st, 8'hDF);
      chk(8'(pins), 8'h03);
      cyc(2);
      chk(outputShortStatus, 8'hFF);
      cmpBelowLow  = 4'h0;
      cmpAboveBias = 4'h0;
   endtask
   task automatic t_latch;
      cmpOvercurrent = 4'h4;
      cyc(1);
      cmpOvercurrent = 4'h0;
      cyc(2);
      chk({overcurrent_n, channelHighZ}, 8'hB4);
      chk(8'(faultPin), 8'h00);
      cyc(4);
      chk({overcurrent_n, channelHighZ}, 8'hB4);
      overcurrentClearW1 = 4'h4;
      cyc(1);
      overcurrentClearW1 = 4'h0;
      cyc(2);
      chk({overcurrent_n, channelHighZ[2:0], faultPin}, 8'hF1);
      cmpShortedLoad = 4'h1;
      cyc(3);
      cmpShortedLoad = 4'h0;
      cyc(3);
      chk(8'(channelHighZ), 8'h01);
      overcurrentClearW1 = 4'h1;
      host_u.set_mode(1'b0);
      overcurrentClearW1 = 4'h0;
      cmpOvercurrent = 4'h8;
      cyc(4);
      chk(8'(channelHighZ), 8'h00);
      cmpOvercurrent = 4'h0;
      cyc(3);
      overcurrentClearW1 = 4'hF;
      host_u.set_mode(1'b1);
      overcurrentClearW1 = 4'h0;
      cyc(1);
      chk({overcurrent_n, channelHighZ}, 8'hF0);
   endtask
   task automatic t_reset;
      cmpOvercurrent = 4'h2;
      cyc(1);
      cmpOvercurrent = 4'h0;
      cyc(1);
      overcurrentClearW1 = 4'h2;
      cyc(1);
      overcurrentClearW1 = 4'h0;
      cyc(1);
      chk({overcurrent_n, channelHighZ}, 8'hD2);
      reset = 1'b1;
      cyc(2);
      chk({overcurrent_n, channelHighZ}, 8'hF0);
      reset = 1'b0;
      cyc(2);
      chk({overcurrent_n, outputShortStatus[3:0]}, 8'hFF);
   endtask
   task automatic t_live;
      cmpOffsetHigh  = 4'h9;
      cmpOvervoltage = 1'b1;
      cmpClip        = 4'h2;
      cyc(3);
      chk(offsetAndVersionStatus, 8'h06);
      chk({outputsHalfSupply, faultPin, clipPins, channelHighZ}, 8'h80);
      chk(8'(clipPins), 8'h00);
      cmpOffsetHigh  = 4'h0;
      cmpOvervoltage = 1'b0;
      cmpClip        = 4'h0;
      cyc(3);
      chk(offsetAndVersionStatus, 8'h0F);
      chk({outputsHalfSupply, faultPin, clipPins, channelHighZ}, 8'h70);
   endtask
   initial begin
      cyc(10);
      reset = 1'b0;
      chk({outputShortStatus[3:0], overcurrent_n}, 8'hFF);
      chk(offsetAndVersionStatus, 8'h0F);
      t_short();
      t_latch();
      t_reset();
      t_live();
      end_of_test();
   end
   initial begin
      #20000;
      nMismatch++;
      end_of_test();
   end
endmodule
